/* design/pag_port_a.sv */
// Contract
// - Direction bit 1 output, 0 input
// - Mode 3: pin 7 drives address 20
// - Direction register reads back all ones
// - Direction reset 00, or 80 in mode 3
// - Software standby holds driven pin outputs
// - Port read: data if output, pin if input
// - Data register: eight read/write bits
// - Data clears on reset and hardware standby, kept in software standby
// - Data register holds pattern groups 0, 1
// - Pattern-enabled bits change only by transfer
// - Pin 7: timer, port or pattern select
// - B-control 001 or 01x selects timer
// - B2 capture: B bit2 set, PWM off
// - Pin 6: timer, port, pattern, address 21
// - Pin 6 timer output: PWM or code
// - A2 capture whenever A bit2 set
// - Direction at FFD1, data at FFD3
module pag_port_a
  import pag_pkg::*;
#(
  parameter int WIDTH = PAG_PORT_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [2:0] opMode,
  input wire logic hwStandby,
  input wire logic swStandby,
  input wire logic [WIDTH-1:0] nextDataEnable,
  input wire logic [WIDTH-1:0] nextData,
  input wire logic nextDataXfer,
  input wire logic chan2PwmMode,
  input wire logic [2:0] aCtrl,
  input wire logic [2:0] bCtrl,
  input wire logic addr21Enable,
  input wire logic timerA2Compare,
  input wire logic timerB2Compare,
  input wire logic [1:0] addrHigh,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe,
  output logic timerA2Capture,
  output logic timerB2Capture
);

  pag_pin_if pins ();

  pag_bus_e busState_q;
  pag_bus_e busState_d;
  logic wrIsDir_q;
  logic wrIsDir_d;
  logic initPending_q;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] dir_d;
  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;
  logic [31:0] hrdata_d;
  logic [WIDTH-1:0] pinOut_d;
  logic [WIDTH-1:0] pinOe_d;
  logic [WIDTH-1:0] portRead;
  logic addrPhase;
  logic hitDir;
  logic hitData;
  logic mode3;
  logic wrDir;
  logic wrData;

  assign mode3 = (opMode == PAG_MODE_3);

  // Address phase decode; hsize is not checked since only words are issued
  always_comb begin
    addrPhase = hsel & hready & (htrans == PAG_HTRANS_NONSEQ);
    hitDir = (haddr[PAG_INDEX_MSB:PAG_INDEX_LSB] == PAG_DIR_INDEX);
    hitData = (haddr[PAG_INDEX_MSB:PAG_INDEX_LSB] == PAG_DATA_INDEX);
  end

  // Data-phase tracker
  always_comb begin
    busState_d = PAG_BUS_IDLE;
    wrIsDir_d = wrIsDir_q;
    if (addrPhase) begin
      if (!hwrite) begin
        busState_d = PAG_BUS_READ;
      end else if (hitDir || hitData) begin
        busState_d = PAG_BUS_WRITE;
        wrIsDir_d = hitDir;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busState_q <= PAG_BUS_IDLE;
      wrIsDir_q <= 1'b0;
    end else begin
      busState_q <= busState_d;
      wrIsDir_q <= wrIsDir_d;
    end
  end

  always_comb begin
    wrDir = (busState_q == PAG_BUS_WRITE) && wrIsDir_q;
    wrData = (busState_q == PAG_BUS_WRITE) && !wrIsDir_q;
  end

  // Mode strap is sampled on the first edge after release, not under reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      initPending_q <= 1'b1;
    end else begin
      initPending_q <= 1'b0;
    end
  end

  // Direction register next value
  always_comb begin
    dir_d = dir_q;
    if (initPending_q || hwStandby) begin
      dir_d = pag_dir_reset(opMode);
    end else if (wrDir) begin
      dir_d = hwdata[WIDTH-1:0];
    end
    if (mode3) begin
      dir_d[PAG_PIN_ADDR20] = 1'b1;
    end
  end

  // Data register next value; a write and a transfer in one cycle both land
  always_comb begin
    data_d = data_q;
    if (initPending_q || hwStandby) begin
      data_d = PAG_DATA_RST;
    end else begin
      if (wrData) begin
        data_d = (data_q & nextDataEnable) | (hwdata[WIDTH-1:0] & ~nextDataEnable);
      end
      if (nextDataXfer) begin
        data_d = (data_d & ~nextDataEnable) | (nextData & nextDataEnable);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= PAG_DIR_RST_NORMAL;
    end else begin
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= PAG_DATA_RST;
    end else begin
      data_q <= data_d;
    end
  end

  // Forwarded values so a read right after a write sees the new contents
  always_comb begin
    portRead = (data_d & dir_d) | (pinIn & ~dir_d);
  end

  always_comb begin
    hrdata_d = hrdata;
    if (addrPhase && !hwrite) begin
      if (hitDir) begin
        hrdata_d = {24'h00_0000, PAG_DIR_READBACK};
      end else if (hitData) begin
        hrdata_d = {24'h00_0000, portRead};
      end else begin
        hrdata_d = PAG_UNMAPPED_READ;
      end
    end
  end

  // Zero-wait slave: hreadyout and hresp are constant flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= PAG_UNMAPPED_READ;
      hreadyout <= 1'b1;
      hresp <= PAG_HRESP_OKAY;
    end else begin
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= PAG_HRESP_OKAY;
    end
  end

  // Shared-pin selection for pins 7 and 6
  always_comb begin
    pins.mode3 = mode3;
    pins.dir7 = dir_q[PAG_PIN_ADDR20];
    pins.dir6 = dir_q[PAG_PIN_ADDR21];
    pins.data7 = data_q[PAG_PIN_ADDR20];
    pins.data6 = data_q[PAG_PIN_ADDR21];
    pins.pattern7 = nextDataEnable[PAG_PIN_ADDR20];
    pins.pattern6 = nextDataEnable[PAG_PIN_ADDR21];
    pins.pwmMode = chan2PwmMode;
    pins.aCtrl = aCtrl;
    pins.bCtrl = bCtrl;
    pins.addr21Enable = addr21Enable;
    pins.timerA2Compare = timerA2Compare;
    pins.timerB2Compare = timerB2Compare;
    pins.addrHigh = addrHigh;
    pins.pin7In = pinIn[PAG_PIN_ADDR20];
    pins.pin6In = pinIn[PAG_PIN_ADDR21];
  end

  pag_pin_mux u_pin_mux (
    .pins(pins)
  );

  // Lower pins: plain port or pattern, both from the data register
  always_comb begin
    pinOe_d = dir_q;
    pinOut_d = data_q;
    pinOe_d[PAG_PIN_ADDR20] = pins.oe7;
    pinOut_d[PAG_PIN_ADDR20] = pins.out7;
    pinOe_d[PAG_PIN_ADDR21] = pins.oe6;
    pinOut_d[PAG_PIN_ADDR21] = pins.out6;
  end

  // Software standby freezes the pads so external loads see no glitch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinOe <= PAG_DIR_RST_NORMAL;
      pinOut <= PAG_DATA_RST;
    end else if (!swStandby) begin
      pinOe <= pinOe_d;
      pinOut <= pinOut_d;
    end else begin
      pinOe <= pinOe;
      pinOut <= pinOut;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timerA2Capture <= 1'b0;
      timerB2Capture <= 1'b0;
    end else begin
      timerA2Capture <= pins.capA;
      timerB2Capture <= pins.capB;
    end
  end

endmodule : pag_port_a

/* design/pag_pkg.sv */
package pag_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] PAG_DIR_INDEX = 16'hFFD1;
  localparam logic [15:0] PAG_DATA_INDEX = 16'hFFD3;
  localparam int PAG_INDEX_LSB = 2;
  localparam int PAG_INDEX_MSB = 17;

  localparam int PAG_PORT_WIDTH = 8;
  localparam int PAG_PIN_ADDR20 = 7;
  localparam int PAG_PIN_ADDR21 = 6;

  localparam logic [7:0] PAG_DIR_RST_NORMAL = 8'h00;
  localparam logic [7:0] PAG_DIR_RST_MODE3 = 8'h80;
  localparam logic [7:0] PAG_DATA_RST = 8'h00;
  localparam logic [7:0] PAG_DIR_READBACK = 8'hFF;
  localparam logic [31:0] PAG_UNMAPPED_READ = 32'h0000_0000;

  localparam logic [2:0] PAG_MODE_3 = 3'h3;

  localparam logic [1:0] PAG_HTRANS_NONSEQ = 2'h2;
  localparam logic PAG_HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    PAG_BUS_IDLE = 2'b00,
    PAG_BUS_WRITE = 2'b01,
    PAG_BUS_READ = 2'b11
  } pag_bus_e;

  // Channel 2 I/O control code: 001 or 01x selects compare output
  function automatic logic pag_ctrl_drives(input logic [2:0] code);
    pag_ctrl_drives = ~code[2] & (|code[1:0]);
  endfunction : pag_ctrl_drives

  function automatic logic [7:0] pag_dir_reset(input logic [2:0] mode);
    pag_dir_reset = (mode == PAG_MODE_3) ? PAG_DIR_RST_MODE3 : PAG_DIR_RST_NORMAL;
  endfunction : pag_dir_reset

endpackage : pag_pkg

/* design/pag_pin_if.sv */
interface pag_pin_if;
  logic mode3;
  logic dir7;
  logic dir6;
  logic data7;
  logic data6;
  logic pattern7;
  logic pattern6;
  logic pwmMode;
  logic [2:0] aCtrl;
  logic [2:0] bCtrl;
  logic addr21Enable;
  logic timerA2Compare;
  logic timerB2Compare;
  logic [1:0] addrHigh;
  logic pin7In;
  logic pin6In;
  logic out7;
  logic out6;
  logic oe7;
  logic oe6;
  logic capA;
  logic capB;

  modport port (
    output mode3, dir7, dir6, data7, data6, pattern7, pattern6, pwmMode, aCtrl, bCtrl,
    output addr21Enable, timerA2Compare, timerB2Compare, addrHigh, pin7In, pin6In,
    input out7, out6, oe7, oe6, capA, capB
  );

  modport mux (
    input mode3, dir7, dir6, data7, data6, pattern7, pattern6, pwmMode, aCtrl, bCtrl,
    input addr21Enable, timerA2Compare, timerB2Compare, addrHigh, pin7In, pin6In,
    output out7, out6, oe7, oe6, capA, capB
  );
endinterface : pag_pin_if

/* design/pag_pin_mux.sv */
module pag_pin_mux
  import pag_pkg::*;
(
  pag_pin_if.mux pins
);

  logic bSelOut;
  logic aSelOut;

  always_comb begin
    bSelOut = pag_ctrl_drives(pins.bCtrl);
    aSelOut = pins.pwmMode | pag_ctrl_drives(pins.aCtrl);
  end

  // Pin 7: address line in mode 3, else timer, else port or pattern
  always_comb begin
    if (pins.mode3) begin
      pins.oe7 = 1'b1;
      pins.out7 = pins.addrHigh[0];
    end else if (bSelOut) begin
      pins.oe7 = 1'b1;
      pins.out7 = pins.timerB2Compare;
    end else begin
      pins.oe7 = pins.dir7;
      // Pattern and port both drive the stored bit
      pins.out7 = pins.pattern7 ? pins.data7 : pins.data7;
    end
  end

  // Pin 6: address line in mode 3 only while the address-21 enable is clear
  always_comb begin
    if (pins.mode3 && !pins.addr21Enable) begin
      pins.oe6 = 1'b1;
      pins.out6 = pins.addrHigh[1];
    end else if (aSelOut) begin
      pins.oe6 = 1'b1;
      pins.out6 = pins.timerA2Compare;
    end else begin
      pins.oe6 = pins.dir6;
      pins.out6 = pins.pattern6 ? pins.data6 : pins.data6;
    end
  end

  // Capture inputs listen alongside whatever drives the pin
  always_comb begin
    pins.capB = pins.bCtrl[2] & ~pins.pwmMode & pins.pin7In;
    pins.capA = pins.aCtrl[2] & pins.pin6In;
  end

endmodule : pag_pin_mux

/* testbench/pag_port_a_sva.sv */
module pag_port_a_sva
  import pag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [2:0] opMode,
  input wire logic swStandby,
  input wire logic chan2PwmMode,
  input wire logic [2:0] aCtrl,
  input wire logic [2:0] bCtrl,
  input wire logic addr21Enable,
  input wire logic timerA2Compare,
  input wire logic timerB2Compare,
  input wire logic [1:0] addrHigh,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic timerA2Capture,
  input wire logic timerB2Capture
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Pins lag the direction load by one edge after reset
  logic [1:0] armQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) armQ <= 2'h0;
    else armQ <= {armQ[0], 1'h1};
  end
  addr20_drive_a: assert property (armQ[1] && !$past(swStandby) && opMode == PAG_MODE_3
    |-> pinOe[7] && pinOut[7] == $past(addrHigh[0])) else $error("pin 7 address");
  addr21_drive_a: assert property (armQ[1] && !$past(swStandby || addr21Enable) && opMode == PAG_MODE_3
    |-> pinOe[6] && pinOut[6] == $past(addrHigh[1])) else $error("pin 6 address");
  b2_compare_a: assert property (armQ[1] && !$past(swStandby || bCtrl[2]) && $past(|bCtrl[1:0])
    && opMode != PAG_MODE_3 |-> pinOe[7] && pinOut[7] == $past(timerB2Compare)) else $error("pin 7 timer");
  a2_compare_a: assert property (armQ[1] && !$past(swStandby) && opMode != PAG_MODE_3
    && $past(chan2PwmMode || !aCtrl[2] && |aCtrl[1:0]) |-> pinOe[6] && pinOut[6] == $past(timerA2Compare))
    else $error("pin 6 timer");
  a2_capture_a: assert property (armQ[0] |-> timerA2Capture == $past(aCtrl[2] & pinIn[6]))
    else $error("A2 capture");
  b2_capture_a: assert property (armQ[0] |-> timerB2Capture == $past(bCtrl[2] & !chan2PwmMode & pinIn[7]))
    else $error("B2 capture");
  standby_hold_a: assert property (armQ[1] && $past(swStandby) |-> $stable(pinOut) && $stable(pinOe))
    else $error("pins moved in standby");
  dir_ones_a: assert property (hsel && hready && htrans == PAG_HTRANS_NONSEQ && !hwrite
    && haddr[17:2] == PAG_DIR_INDEX |=> hrdata[7:0] == PAG_DIR_READBACK) else $error("direction read");
endmodule : pag_port_a_sva

bind pag_port_a pag_port_a_sva chk (.*);

/* testbench/pag_pin_model.sv */
module pag_pin_model (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] extLevel,
  output logic [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins fall back to the board level
  assign pinIn = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule : pag_pin_model

/* testbench/tb_pag_port_a.sv */
module tb_pag_port_a import pag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] opMode = 3'h1;
  logic hwStandby = 1'h0, swStandby = 1'h0, nextDataXfer = 1'h0;
  logic [7:0] nextDataEnable = 8'h0, nextData = 8'h0;
  logic chan2PwmMode = 1'h0, addr21Enable = 1'h0;
  logic timerA2Compare = 1'h0, timerB2Compare = 1'h0;
  logic [2:0] aCtrl = 3'h0, bCtrl = 3'h0, k;
  logic [1:0] addrHigh = 2'h0;
  logic hreadyout, hresp, timerA2Capture, timerB2Capture;
  logic [31:0] hrdata;
  logic [7:0] pinIn, pinOut, pinOe;
  int failures = 0;
  int checks = 0;
  pag_port_a dut (
    .hready(hreadyout),
    .hsize(3'h2),
    .*
  );
  pag_pin_model pins (
    .pinOut(pinOut),
    .pinOe(pinOe),
    .extLevel(8'hC3),
    .pinIn(pinIn)
  );
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        failures++;
        give_verdict();
      end
    end while (hreadyout !== 1'h1);
  endtask : waitRdy
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    hsel <= 1'h1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= PAG_HTRANS_NONSEQ;
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= {24'h0, d};
    waitRdy();
    chk(hresp, PAG_HRESP_OKAY);
  endtask : xfer
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    xfer(1'h0, idx, 8'h0);
    chk(hrdata, {24'h0, exp});
  endtask : rd
  task automatic step();
    @(posedge clk_sys);
  endtask : step
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic doReset(input logic [2:0] m);
    rst_n <= 1'h0;
    opMode <= m;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : doReset
  initial begin
    doReset(3'h1);
    chk(pinOe, 32'h0);
    rd(PAG_DIR_INDEX, 8'hFF);
    rd(PAG_DATA_INDEX, 8'hC3);
    rd(16'hFFD2, 8'h00);
    xfer(1'h1, PAG_DIR_INDEX, 8'h0F);
    xfer(1'h1, PAG_DATA_INDEX, 8'hA5);
    settle();
    chk(pinOe, 8'h0F);
    chk(pinOut[3:0], 4'h5);
    rd(PAG_DATA_INDEX, 8'hC5);
    $display("port test done");
    nextDataEnable <= 8'h03;
    nextData <= 8'h02;
    xfer(1'h1, PAG_DATA_INDEX, 8'h00);
    rd(PAG_DATA_INDEX, 8'hC1);
    nextDataXfer <= 1'h1;
    step();
    nextDataXfer <= 1'h0;
    rd(PAG_DATA_INDEX, 8'hC2);
    settle();
    chk(pinOut[3:0], 4'h2);
    $display("pattern test done");
    step();
    swStandby <= 1'h1;
    xfer(1'h1, PAG_DATA_INDEX, 8'hFF);
    settle();
    chk(pinOut[3:0], 4'h2);
    rd(PAG_DATA_INDEX, 8'hCE);
    swStandby <= 1'h0;
    settle();
    chk(pinOut[3:0], 4'hE);
    step();
    nextDataEnable <= 8'h00;
    hwStandby <= 1'h1;
    step();
    hwStandby <= 1'h0;
    settle();
    chk(pinOe, 8'h00);
    rd(PAG_DATA_INDEX, 8'hC3);
    $display("standby test done");
    xfer(1'h1, PAG_DIR_INDEX, 8'hC0);
    xfer(1'h1, PAG_DATA_INDEX, 8'h80);
    settle();
    chk(pinOe[7:6], 2'h3);
    chk(pinOut[7:6], 2'h2);
    step();
    nextDataEnable <= 8'hC0;
    nextData <= 8'h40;
    nextDataXfer <= 1'h1;
    step();
    nextDataXfer <= 1'h0;
    settle();
    chk(pinOut[7:6], 2'h1);
    step();
    nextDataEnable <= 8'h00;
    xfer(1'h1, PAG_DIR_INDEX, 8'h00);
    $display("shared pin test done");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        k = c[2:0];
        step();
        chan2PwmMode <= p[0];
        aCtrl <= k;
        bCtrl <= k;
        timerA2Compare <= k[0];
        timerB2Compare <= !k[0];
        settle();
        chk(pinOe[7], k == 3'h1 || k[2:1] == 2'h1);
        chk(pinOe[6], p[0] || k == 3'h1 || k[2:1] == 2'h1);
        if (k == 3'h1 || k[2:1] == 2'h1) begin
          chk(pinOut[7], !k[0]);
        end
        if (p[0] || k == 3'h1 || k[2:1] == 2'h1) begin
          chk(pinOut[6], k[0]);
        end
        chk(timerA2Capture, k[2] & (p[0] ? k[0] : 1'h1));
        chk(timerB2Capture, k[2] & !p[0]);
      end
    end
    $display("timer test done");
    step();
    aCtrl <= 3'h0;
    bCtrl <= 3'h0;
    chan2PwmMode <= 1'h0;
    addrHigh <= 2'h1;
    doReset(3'h3);
    chk(pinOe, 8'hC0);
    chk(pinOut[7:6], 2'h2);
    xfer(1'h1, PAG_DIR_INDEX, 8'h00);
    addr21Enable <= 1'h1;
    settle();
    chk(pinOe, 8'h80);
    rd(PAG_DIR_INDEX, 8'hFF);
    rd(PAG_DATA_INDEX, 8'h43);
    $display("mode 3 test done");
    give_verdict();
  end
endmodule : tb_pag_port_a
